/* File: common/rsmc_map.vh */
// register offsets, field positions, reset values and timing counts for the mode control block
`ifndef RSMC_MAP_VH
`define RSMC_MAP_VH

// ==========================================================
// register offsets
`define RSMC_OFS_A_DIV 6'h01
`define RSMC_OFS_N_DIV 6'h02
`define RSMC_OFS_CTRL 6'h03
`define RSMC_OFS_RATE 6'h04
`define RSMC_OFS_CHAN 6'h21
`define RSMC_OFS_SETTLE 6'h38

// ==========================================================
// reset values
`define RSMC_RST_N_DIV 8'h00
`define RSMC_RST_CTRL 8'h00

// ==========================================================
// field positions
`define RSMC_N_MSB 6
`define RSMC_CTL_RX 7
`define RSMC_CTL_TX 6
`define RSMC_CTL_HALF 5
`define RSMC_CTL_SETTLE_CNT 4
`define RSMC_CTL_AMP_MAN 3
`define RSMC_CTL_AMP_ON 2
`define RSMC_CTL_SYN_MAN 1
`define RSMC_CTL_SYN_ON 0
`define RSMC_RATE_WIDTH32 2
`define RSMC_CHAN_DIRECT 7

// ==========================================================
// timing
`define RSMC_SETTLE_UNIT_NS 2000
`define RSMC_CLK_NS 40
`define RSMC_SETTLE_UNIT_CYC (`RSMC_SETTLE_UNIT_NS / `RSMC_CLK_NS)

`endif

/* File: core/rsmc_settle_timer.v */
// synthesizer settle timer: counted lock time or lock indication
`timescale 1ns/1ns
`default_nettype none
`include "rsmc_map.vh"

module rsmc_settle_timer #(
  parameter UNIT_CYC = `RSMC_SETTLE_UNIT_CYC
) (
  input wire mclk_i,
  input wire sys_rst_i,
  input wire start_i,
  input wire use_count_i,
  input wire [7:0] count_i,
  input wire lock_i,
  output reg settled_o
);

  reg [7:0] units_r;
  reg [11:0] tick_r;
  reg busy_r;
  wire tick_end;

  assign tick_end = (tick_r == UNIT_CYC[11:0] - 12'h001);

  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      units_r <= 8'h00;
      tick_r <= 12'h000;
      busy_r <= 1'b0;
      settled_o <= 1'b0;
    end else if (start_i) begin
      units_r <= count_i;
      tick_r <= 12'h000;
      busy_r <= 1'b1;
      settled_o <= 1'b0;
    end else if (busy_r) begin
      if (use_count_i) begin
        // count of 2 us units
        if (units_r == 8'h00) begin
          busy_r <= 1'b0;
          settled_o <= 1'b1;
        end else if (tick_end) begin
          tick_r <= 12'h000;
          units_r <= units_r - 8'h01;
        end else begin
          tick_r <= tick_r + 12'h001;
        end
      end else if (lock_i) begin
        busy_r <= 1'b0;
        settled_o <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

/* File: core/rsmc_top.v */
// register logic for synthesizer divider readback and radio mode control
`timescale 1ns/1ns
`default_nettype none
`include "rsmc_map.vh"

// How it works
// - n divider keeps seven count bits; top bit reserved, written zero.
// - channel bit 7 picks channel-derived or direct a/n programming.
// - in channel mode, a and n reads return channel-derived dividers.
// - control bit 7 enables receive.
// - control bit 6 enables transmit.
// - bit 5 picks upper or lower code half in 32-chip mode.
// - bit 4 times settling by lock count, else by lock signal.
// - bit 3 set makes amplifier follow bit 2, else baseband drives it.
// - bit 2 switches amplifier, ignored unless manual amplifier mode.
// - bit 1 set makes synthesizer follow bit 0, else automatic control.
// - bit 0 enables synthesizer, ignored unless manual synthesizer mode.
// - rate bit 2 selects 32-chip codes, gating half selection.
module rsmc_top #(
  parameter UNIT_CYC = `RSMC_SETTLE_UNIT_CYC
) (
  input wire mclk_i,
  input wire sys_rst_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [5:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire [7:0] channel_i,
  input wire [7:0] data_rate_i,
  input wire [7:0] settle_time_count_i,
  input wire [4:0] synth_a_divider_i,
  input wire [4:0] chan_a_div_i,
  input wire [6:0] chan_n_div_i,
  input wire syn_lock_i,
  input wire bb_amp_req_i,
  input wire bb_syn_req_i,
  output reg [7:0] reg_rdata_o,
  output reg rx_enable_o,
  output reg tx_enable_o,
  output reg spread_half_select_o,
  output reg amp_power_on_o,
  output reg synth_enable_o,
  output reg synth_settled_o,
  output reg direct_div_o,
  output reg [4:0] synth_a_div_o,
  output reg [6:0] synth_n_div_o
);

  // ==========================================================
  // register storage
  reg [7:0] synth_n_divider_r;
  reg [7:0] radio_mode_control_r;
  reg [7:0] synth_n_divider_nxt;
  reg [7:0] radio_mode_control_nxt;
  reg syn_req_q_r;
  reg [7:0] rd_nxt;

  // ==========================================================
  // address decode
  wire hit_a_div;
  wire hit_n_div;
  wire hit_ctrl;
  wire wr_n_div;
  wire wr_ctrl;

  // ==========================================================
  // control fields
  wire ctl_rx;
  wire ctl_tx;
  wire ctl_half;
  wire ctl_settle_cnt;
  wire ctl_amp_man;
  wire ctl_amp_on;
  wire ctl_syn_man;
  wire ctl_syn_on;

  // ==========================================================
  // derived controls
  wire direct_mode;
  wire width32;
  wire syn_req;
  wire syn_start;
  wire settle_done;
  wire [4:0] a_sel;
  wire [6:0] n_sel;

  // ==========================================================
  // output next values
  reg rx_enable_nxt;
  reg tx_enable_nxt;
  reg spread_half_select_nxt;
  reg amp_power_on_nxt;
  reg synth_enable_nxt;
  reg synth_settled_nxt;
  reg direct_div_nxt;
  reg [4:0] synth_a_div_nxt;
  reg [6:0] synth_n_div_nxt;

  // ==========================================================
  // address decode logic
  assign hit_a_div = (reg_addr_i == `RSMC_OFS_A_DIV);
  assign hit_n_div = (reg_addr_i == `RSMC_OFS_N_DIV);
  assign hit_ctrl = (reg_addr_i == `RSMC_OFS_CTRL);
  // writes aimed at registers kept elsewhere are dropped here
  assign wr_n_div = reg_wr_i & hit_n_div;
  assign wr_ctrl = reg_wr_i & hit_ctrl;

  // ==========================================================
  // register next values
  always @* begin
    synth_n_divider_nxt = synth_n_divider_r;
    if (wr_n_div) begin
      // reserved top bit is kept zero so a stray write cannot leak
      synth_n_divider_nxt = {1'b0, reg_wdata_i[`RSMC_N_MSB:0]};
    end
  end

  always @* begin
    radio_mode_control_nxt = radio_mode_control_r;
    if (wr_ctrl) begin
      radio_mode_control_nxt = reg_wdata_i;
    end
  end

  // ==========================================================
  // register flops
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      synth_n_divider_r <= `RSMC_RST_N_DIV;
    end else begin
      synth_n_divider_r <= synth_n_divider_nxt;
    end
  end

  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      radio_mode_control_r <= `RSMC_RST_CTRL;
    end else begin
      radio_mode_control_r <= radio_mode_control_nxt;
    end
  end

  // ==========================================================
  // control field split
  assign ctl_rx = radio_mode_control_r[`RSMC_CTL_RX];
  assign ctl_tx = radio_mode_control_r[`RSMC_CTL_TX];
  assign ctl_half = radio_mode_control_r[`RSMC_CTL_HALF];
  assign ctl_settle_cnt = radio_mode_control_r[`RSMC_CTL_SETTLE_CNT];
  assign ctl_amp_man = radio_mode_control_r[`RSMC_CTL_AMP_MAN];
  assign ctl_amp_on = radio_mode_control_r[`RSMC_CTL_AMP_ON];
  assign ctl_syn_man = radio_mode_control_r[`RSMC_CTL_SYN_MAN];
  assign ctl_syn_on = radio_mode_control_r[`RSMC_CTL_SYN_ON];

  // ==========================================================
  // divider source selection
  assign direct_mode = channel_i[`RSMC_CHAN_DIRECT];
  assign a_sel = direct_mode ? synth_a_divider_i : chan_a_div_i;
  assign n_sel = direct_mode ? synth_n_divider_r[`RSMC_N_MSB:0] : chan_n_div_i;
  assign width32 = data_rate_i[`RSMC_RATE_WIDTH32];

  // ==========================================================
  // read data
  // a divider read is answered here too so channel-mode readback stays in one place
  always @* begin
    rd_nxt = 8'h00;
    case (reg_addr_i)
      `RSMC_OFS_A_DIV: begin
        rd_nxt = {3'h0, a_sel};
      end
      `RSMC_OFS_N_DIV: begin
        rd_nxt = {1'b0, n_sel};
      end
      `RSMC_OFS_CTRL: begin
        rd_nxt = radio_mode_control_r;
      end
      default: begin
        rd_nxt = 8'h00;
      end
    endcase
  end

  // ==========================================================
  // synthesizer request
  assign syn_req = ctl_syn_man ? ctl_syn_on : bb_syn_req_i;
  // timer only restarts on a rising request; a held request keeps its result
  assign syn_start = syn_req & ~syn_req_q_r;

  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      syn_req_q_r <= 1'b0;
    end else begin
      syn_req_q_r <= syn_req;
    end
  end

  // ==========================================================
  // settle timer
  // lock count is taken once at the rising request; later writes wait for the next
  rsmc_settle_timer #(
    .UNIT_CYC(UNIT_CYC)
  ) u_settle (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .start_i(syn_start),
    .use_count_i(ctl_settle_cnt),
    .count_i(settle_time_count_i),
    .lock_i(syn_lock_i),
    .settled_o(settle_done)
  );

  // ==========================================================
  // output next value logic
  always @* begin
    rx_enable_nxt = ctl_rx;
    tx_enable_nxt = ctl_tx;
  end

  always @* begin
    // half select only meaningful for 32-chip codes, else low half
    spread_half_select_nxt = width32 & ctl_half;
  end

  always @* begin
    if (ctl_amp_man) begin
      amp_power_on_nxt = ctl_amp_on;
    end else begin
      amp_power_on_nxt = bb_amp_req_i;
    end
  end

  always @* begin
    synth_enable_nxt = syn_req;
    synth_settled_nxt = syn_req & settle_done;
  end

  always @* begin
    direct_div_nxt = direct_mode;
    synth_a_div_nxt = a_sel;
    synth_n_div_nxt = n_sel;
  end

  // ==========================================================
  // read data output
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      // holds between reads so the host may fetch it late
      reg_rdata_o <= rd_nxt;
    end
  end

  // ==========================================================
  // mode outputs
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rx_enable_o <= 1'b0;
      tx_enable_o <= 1'b0;
      spread_half_select_o <= 1'b0;
      amp_power_on_o <= 1'b0;
    end else begin
      rx_enable_o <= rx_enable_nxt;
      tx_enable_o <= tx_enable_nxt;
      spread_half_select_o <= spread_half_select_nxt;
      amp_power_on_o <= amp_power_on_nxt;
    end
  end

  // ==========================================================
  // synthesizer outputs
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      synth_enable_o <= 1'b0;
      synth_settled_o <= 1'b0;
    end else begin
      synth_enable_o <= synth_enable_nxt;
      synth_settled_o <= synth_settled_nxt;
    end
  end

  // ==========================================================
  // divider outputs
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      direct_div_o <= 1'b0;
      synth_a_div_o <= 5'h00;
      synth_n_div_o <= 7'h00;
    end else begin
      direct_div_o <= direct_div_nxt;
      synth_a_div_o <= synth_a_div_nxt;
      synth_n_div_o <= synth_n_div_nxt;
    end
  end

endmodule
`default_nettype wire

/* File: tb/rsmc_checker.sv */
// port assertions for the mode control block
`timescale 1ns/1ns
`default_nettype none
module rsmc_checker (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [5:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] data_rate_i,
  input wire logic bb_amp_req_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic rx_enable_o,
  input wire logic tx_enable_o,
  input wire logic spread_half_select_o,
  input wire logic amp_power_on_o,
  input wire logic synth_enable_o
);
  // ==========================================
  // control write shows on the second edge
  wire w3 = reg_wr_i && reg_addr_i == 6'h03;
  wire [7:0] wd = reg_wdata_i;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  a_rx_follow: assert property (w3 |-> ##2 rx_enable_o == $past(wd[7], 2))
    else $error("rx mismatch");
  a_tx_follow: assert property (w3 |-> ##2 tx_enable_o == $past(wd[6], 2))
    else $error("tx mismatch");
  a_half_gated: assert property (w3 |-> ##2 spread_half_select_o ==
    ($past(wd[5], 2) && $past(data_rate_i[2]))) else $error("half mismatch");
  a_amp_manual: assert property (w3 && wd[3] |-> ##2 amp_power_on_o == $past(wd[2], 2))
    else $error("amp manual mismatch");
  a_amp_auto: assert property (w3 && !wd[3] |-> ##2 amp_power_on_o == $past(bb_amp_req_i))
    else $error("amp auto mismatch");
  a_syn_manual: assert property (w3 && wd[1] |-> ##2 synth_enable_o == $past(wd[0], 2))
    else $error("synth manual mismatch");
  a_n_top_zero: assert property (reg_rd_i && reg_addr_i == 6'h02 |=> !reg_rdata_o[7])
    else $error("n top bit set");
  a_rst_quiet: assert property (disable iff (1'b0) sys_rst_i |->
    !(rx_enable_o || tx_enable_o || amp_power_on_o || synth_enable_o)) else $error("reset");
endmodule
bind rsmc_top rsmc_checker u_rsmc_checker (.*);
`default_nettype wire

/* File: tb/rsmc_lock_model.sv */
// synthesizer lock model: lock rises a fixed time after enable
`timescale 1ns/1ns
`default_nettype none
module rsmc_lock_model #(parameter int DELAY = 20) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic en_i,
  output var logic lock_o
);
  // ==========================================
  // slower than counted settling so the two methods differ
  int cnt;
  always @(posedge mclk_i) begin
    if (rst_i || !en_i) begin
      cnt <= 0;
      lock_o <= 1'b0;
    end else begin
      if (cnt < DELAY) cnt <= cnt + 1;
      lock_o <= cnt >= DELAY;
    end
  end
endmodule
`default_nettype wire

/* File: tb/rsmc_top_tb_top.sv */
// directed bench for the mode control register block
`timescale 1ns/1ns
`default_nettype none
module rsmc_top_tb_top;
  logic mclk_i = 0, sys_rst_i = 0, reg_wr_i = 0, reg_rd_i = 0, syn_lock_i;
  logic bb_amp_req_i = 0, bb_syn_req_i = 0, rx_enable_o, tx_enable_o, direct_div_o;
  logic spread_half_select_o, amp_power_on_o, synth_enable_o, synth_settled_o;
  logic [5:0] reg_addr_i = 6'h00;
  logic [7:0] reg_wdata_i = 8'h00, channel_i = 8'h80, data_rate_i = 8'h00, reg_rdata_o;
  logic [7:0] settle_time_count_i = 8'h03;
  logic [4:0] synth_a_divider_i = 5'h11, chan_a_div_i = 5'h0a, synth_a_div_o;
  logic [6:0] chan_n_div_i = 7'h4a, synth_n_div_o;
  int failures = 0, samples_checked = 0, i;
  wire [7:0] outs = {rx_enable_o, tx_enable_o, spread_half_select_o, amp_power_on_o,
    synth_enable_o, 3'h0};
  always #20 mclk_i = ~mclk_i;
  rsmc_top #(.UNIT_CYC(2)) u_rsmc_top (.*);
  rsmc_lock_model u_rsmc_lock_model (.mclk_i(mclk_i), .rst_i(sys_rst_i),
    .en_i(synth_enable_o), .lock_o(syn_lock_i));
  // ==========================================
  // access tasks
  task automatic results;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    reg_wr_i = 1;
    reg_addr_i = a;
    reg_wdata_i = d;
    cyc(1);
    reg_wr_i = 0;
    cyc(1);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    reg_rd_i = 1;
    reg_addr_i = a;
    cyc(1);
    reg_rd_i = 0;
    chk(reg_rdata_o, exp);
    cyc(1);
  endtask
  task automatic ctl(input logic [7:0] d, input logic [7:0] exp);
    wr(6'h03, d);
    cyc(2);
    chk(outs, exp);
  endtask
  // timer restarts only on a rising request, so drop it first
  task automatic settle(input logic [7:0] d, input logic exp);
    wr(6'h03, 8'h00);
    cyc(3);
    wr(6'h03, d);
    for (i = 0; i < 60 && synth_settled_o !== 1'b1; i++) cyc(1);
    if (i == 60) begin
      failures++;
      $display("CHECK FAILED %0t no settle", $time);
      results();
    end
    chk({7'h00, syn_lock_i}, {7'h00, exp});
  endtask
  initial begin
    #1 sys_rst_i = 1;
    cyc(4);
    sys_rst_i = 0;
    rd(6'h03, 8'h00);
    rd(6'h02, 8'h00);
    wr(6'h02, 8'hcb);
    rd(6'h02, 8'h4b);
    rd(6'h01, 8'h11);
    chk({direct_div_o, synth_n_div_o}, 8'hcb);
    chk({3'h0, synth_a_div_o}, 8'h11);
    channel_i = 8'h00;
    rd(6'h02, 8'h4a);
    rd(6'h01, 8'h0a);
    chk({direct_div_o, synth_n_div_o}, 8'h4a);
    chk({3'h0, synth_a_div_o}, 8'h0a);
    ctl(8'h80, 8'h80);
    ctl(8'h40, 8'h40);
    ctl(8'h20, 8'h00);
    data_rate_i = 8'h04;
    ctl(8'h20, 8'h20);
    bb_amp_req_i = 1;
    bb_syn_req_i = 1;
    ctl(8'h05, 8'h18);
    ctl(8'h09, 8'h08);
    ctl(8'h0e, 8'h10);
    bb_amp_req_i = 0;
    bb_syn_req_i = 0;
    settle(8'h03, 1'b1);
    settle(8'h13, 1'b0);
    sys_rst_i = 1;
    cyc(1);
    chk(outs, 8'h00);
    sys_rst_i = 0;
    rd(6'h03, 8'h00);
    results();
  end
endmodule
`default_nettype wire
